// file: lsc_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
module lsc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // flush
  input wire logic flush
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire empty = (wr_reg == rd_reg);
  wire do_wr = in_valid && !full;
  wire do_rd = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_reg[rd_reg[AW-1:0]];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else if (flush) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (do_wr) wr_reg <= wr_reg + 1'b1;
      if (do_rd) rd_reg <= rd_reg + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (do_wr) mem_reg[wr_reg[AW-1:0]] <= in_data;
  end
endmodule : lsc_fifo

// file: lsc_monitor.sv
// checker for the serializer control pins
`timescale 1ns/100ps
module lsc_monitor
  import lsc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // control pins
  input wire logic DESKEW_REQUEST_N,
  input wire logic POWER_DOWN_N,
  input wire logic PLL_RANGE_SELECT,
  input wire logic TERMINATION_SENSE,
  // link side
  input wire logic [LSC_LANES-1:0] SERIAL_LANE_OUT,
  input wire logic SERIAL_CLOCK_OUT,
  input wire logic LANES_ACTIVE,
  input wire logic DESKEW_ACTIVE,
  input wire logic TERMINATION_DETECTED
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  a_deskew_excl: assert property (DESKEW_ACTIVE |-> !LANES_ACTIVE)
    else $error("run during deskew");
  a_deskew_lanes: assert property (
    DESKEW_ACTIVE && $past(DESKEW_ACTIVE) |-> SERIAL_LANE_OUT == 8'h0)
    else $error("lanes busy in deskew");
  a_deskew_clock: assert property (
    DESKEW_ACTIVE && $past(DESKEW_ACTIVE) |-> SERIAL_CLOCK_OUT != $past(SERIAL_CLOCK_OUT))
    else $error("clock lane stuck");
  a_deskew_hold: assert property (!DESKEW_REQUEST_N [*8] |-> !LANES_ACTIVE)
    else $error("run while request low");
  a_deskew_exit: assert property (DESKEW_REQUEST_N [*7] |-> !DESKEW_ACTIVE)
    else $error("deskew after release");
  a_idle_lanes: assert property (
    !LANES_ACTIVE && !$past(LANES_ACTIVE) |-> SERIAL_LANE_OUT == 8'h0)
    else $error("lanes busy while idle");
  a_down_stop: assert property (
    !POWER_DOWN_N [*7] |-> !LANES_ACTIVE && !TERMINATION_DETECTED)
    else $error("active in power-down");
  a_term_none: assert property (!TERMINATION_SENSE [*6] |-> !TERMINATION_DETECTED)
    else $error("false termination");
  a_relock_wait: assert property (
    $rose(LANES_ACTIVE) |-> $past(POWER_DOWN_N, 8) && $past(PLL_RANGE_SELECT, 8))
    else $error("run without lock");
endmodule : lsc_monitor
bind lsc_top lsc_monitor u_mon (.CLK, .RST_B, .DESKEW_REQUEST_N, .POWER_DOWN_N,
  .PLL_RANGE_SELECT, .TERMINATION_SENSE, .SERIAL_LANE_OUT, .SERIAL_CLOCK_OUT,
  .LANES_ACTIVE, .DESKEW_ACTIVE, .TERMINATION_DETECTED);

// file: lsc_pkg.sv
// package of constants and types for the serializer control block
package lsc_pkg;
  localparam int LSC_IN_BITS = 24;
  localparam int LSC_WORD_BITS = 48;
  localparam int LSC_LANES = 8;
  localparam int LSC_BITS_PER_LANE = 6;
  localparam int LSC_DESKEW_MIN_CYC = 4096;
  localparam int LSC_PLL_LOCK_CYC = 64;
  localparam int LSC_FIFO_DEPTH = 32;
  localparam logic [22:0] LSC_PRBS_SEED = 23'h7fffff;
  localparam int LSC_PRBS15_TAP_A = 14;
  localparam int LSC_PRBS15_TAP_B = 13;
  localparam int LSC_PRBS23_TAP_A = 22;
  localparam int LSC_PRBS23_TAP_B = 17;
  localparam int LSC_DCB_FLAG_BIT = 5;
  localparam logic [2:0] LSC_SLOT_LAST = 3'h5;
  typedef enum logic [2:0] {
    LSC_ST_DOWN = 3'b000,
    LSC_ST_LOCK = 3'b001,
    LSC_ST_RUN = 3'b011,
    LSC_ST_DESKEW = 3'b010
  } lsc_state_e;
endpackage : lsc_pkg

// file: lsc_rx_model.sv
// receiver model rebuilding words from the lanes
`timescale 1ns/100ps
module lsc_rx_model
  import lsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // lanes in, word out
  input wire logic [LSC_LANES-1:0] lanes,
  output logic [LSC_WORD_BITS-1:0] rx_word
);
  logic [LSC_WORD_BITS-1:0] word_reg;
  logic [LSC_WORD_BITS-1:0] word_next;
  // slot 0 first, lowest in each group
  always_comb begin
    for (int l = 0; l < LSC_LANES; l++) begin
      word_next[l*6 +: 6] = {lanes[l], word_reg[l*6+1 +: 5]};
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_reg <= '0;
    end else begin
      word_reg <= word_next;
    end
  end
  assign rx_word = word_reg;
endmodule : lsc_rx_model

// file: lsc_top.sv
// serializer control: deskew, pattern generator, power-down, lane output
// Notes on behaviour
// R1 - deskew request held low runs deskew instead of normal transmission
// R2 - no parallel data is sampled while deskew is in progress
// R3 - the host holds deskew request low at least 4096 input clocks
// R4 - the host starts deskew only after both plls have locked
// R5 - the host repeats deskew after any reset or reconfiguration
// R6 - pattern length high picks prbs-23, low or open picks prbs-15
// R7 - pattern generator runs only while its enable is high
// R8 - power-down low puts the device in power-down
// R9 - pll range select is held high by the host; low is reserved
// R10 - termination detected output is high only with remote termination sensed
// R11 - open pulled-down inputs read as low
// R12 - factory straps are held low or left open by the host
// R13 - unused data bits are held low by the host
// R14 - parallel data captured on both rising and falling input clock edges
// R15 - 48 bits per input clock go onto 8 lanes plus a clock lane
// R16 - balance select high enables dc-balanced coding, low disables it
// R17 - after power-down, lanes stay idle until the pll has relocked
// R18 - enabled pattern generator replaces parallel data on the lanes
`timescale 1ns/100ps
module lsc_top
  import lsc_pkg::*;
#(
  parameter int DESKEW_CYC = LSC_DESKEW_MIN_CYC,
  parameter int LOCK_CYC = LSC_PLL_LOCK_CYC,
  parameter int FIFO_DEPTH = LSC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // host side
  input wire logic INPUT_CLOCK,
  input wire logic [LSC_IN_BITS-1:0] PARALLEL_DATA_IN,
  // control pins
  input wire logic DESKEW_REQUEST_N,
  input wire logic PATTERN_LENGTH_SELECT,
  input wire logic PATTERN_GENERATOR_ENABLE,
  input wire logic POWER_DOWN_N,
  input wire logic PLL_RANGE_SELECT,
  input wire logic FACTORY_STRAP_1,
  input wire logic FACTORY_STRAP_2,
  input wire logic DC_BALANCE_ENABLE,
  input wire logic TERMINATION_SENSE,
  // link side
  output logic [LSC_LANES-1:0] SERIAL_LANE_OUT,
  output logic SERIAL_CLOCK_OUT,
  output logic LANES_ACTIVE,
  output logic DESKEW_ACTIVE,
  output logic TERMINATION_DETECTED,
  output logic FIFO_OVERRUN
);
  // counts must fit the 16-bit state counter
  if (DESKEW_CYC < 1 || DESKEW_CYC > 65535 || LOCK_CYC < 1 || LOCK_CYC > 65535) begin : g_bad_cnt
    $error("counts out of range");
  end

  // three-stage synchronisers for every pin input
  localparam int NS = 9 + LSC_IN_BITS;
  wire [NS-1:0] pin_in = {PARALLEL_DATA_IN,
    INPUT_CLOCK, DESKEW_REQUEST_N, PATTERN_LENGTH_SELECT,
    PATTERN_GENERATOR_ENABLE, POWER_DOWN_N, PLL_RANGE_SELECT, DC_BALANCE_ENABLE,
    TERMINATION_SENSE, FACTORY_STRAP_1 | FACTORY_STRAP_2};
  logic [NS-1:0] s1_reg;
  logic [NS-1:0] s2_reg;
  logic [NS-1:0] s3_reg;
  logic [NS-1:0] lvl_reg;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s1_reg <= '0; // see R11
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
    end
  end
  wire clk_lvl = lvl_reg[8];
  wire dsk_n = lvl_reg[7];
  wire len23 = lvl_reg[6]; // see R6
  wire gen_en = lvl_reg[5]; // see R7
  wire pwr_n = lvl_reg[4];
  wire range_ok = lvl_reg[3];
  wire bal_en = lvl_reg[2]; // see R16
  wire term_lvl = lvl_reg[1];
  wire [LSC_IN_BITS-1:0] data_lvl = lvl_reg[NS-1 -: LSC_IN_BITS];

  // input clock edge detection
  logic clk_prev_reg;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) clk_prev_reg <= 1'b0;
    else clk_prev_reg <= clk_lvl;
  end
  wire rise = clk_lvl && !clk_prev_reg;
  wire fall = !clk_lvl && clk_prev_reg;

  // state machine
  lsc_state_e state_reg;
  lsc_state_e state_next;
  logic [15:0] cnt_reg;
  wire lock_done = (cnt_reg >= 16'(LOCK_CYC - 1));
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LSC_ST_DOWN: if (pwr_n && range_ok) state_next = LSC_ST_LOCK;
      LSC_ST_LOCK: if (lock_done && rise) state_next = dsk_n ? LSC_ST_RUN : LSC_ST_DESKEW; // see R17
      LSC_ST_RUN: if (!dsk_n) state_next = LSC_ST_DESKEW; // see R1
      LSC_ST_DESKEW: if (dsk_n) state_next = LSC_ST_RUN;
      default: state_next = LSC_ST_DOWN;
    endcase
    if (!pwr_n) state_next = LSC_ST_DOWN; // see R8
  end
  wire run = (state_reg == LSC_ST_RUN);
  wire dsk = (state_reg == LSC_ST_DESKEW);
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= LSC_ST_DOWN;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) cnt_reg <= '0;
      else if ((state_reg == LSC_ST_LOCK) && rise && !lock_done) cnt_reg <= cnt_reg + 16'h1;
      else if (dsk && rise && cnt_reg != 16'hffff) cnt_reg <= cnt_reg + 16'h1;
    end
  end
  wire dsk_valid = dsk && (cnt_reg >= 16'(DESKEW_CYC)); // see R3

  // double-edge capture: falling half then rising half
  logic [LSC_IN_BITS-1:0] half_reg;
  logic [LSC_WORD_BITS-1:0] word_reg;
  logic word_vld_reg;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      half_reg <= '0;
      word_reg <= '0;
      word_vld_reg <= 1'b0;
    end else begin
      word_vld_reg <= 1'b0;
      if (run && fall) half_reg <= data_lvl; // see R14
      if (run && rise) begin // see R2
        word_reg <= {half_reg, data_lvl}; // see R15
        word_vld_reg <= 1'b1;
      end
    end
  end

  // pattern generator
  function automatic logic [22:0] prbs_step(input logic [22:0] s, input logic long);
    logic fb;
    fb = long ? (s[LSC_PRBS23_TAP_A] ^ s[LSC_PRBS23_TAP_B])
              : (s[LSC_PRBS15_TAP_A] ^ s[LSC_PRBS15_TAP_B]);
    prbs_step = {s[21:0], fb};
  endfunction : prbs_step
  logic [22:0] prbs_reg;
  logic [LSC_WORD_BITS-1:0] pat_word;
  always_comb begin
    logic [22:0] s;
    s = prbs_reg;
    pat_word = '0;
    for (int i = 0; i < LSC_WORD_BITS; i++) begin
      s = prbs_step(s, len23);
      pat_word[i] = s[0];
    end
  end
  logic [22:0] prbs_adv;
  always_comb begin
    prbs_adv = prbs_reg;
    for (int i = 0; i < LSC_WORD_BITS; i++) prbs_adv = prbs_step(prbs_adv, len23);
  end
  wire use_gen = gen_en; // see R18
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) prbs_reg <= LSC_PRBS_SEED;
    else if (!gen_en) prbs_reg <= LSC_PRBS_SEED; // see R7
    else if (run && rise) prbs_reg <= (prbs_adv == '0) ? LSC_PRBS_SEED : prbs_adv;
  end

  // fifo in the data path
  wire [LSC_WORD_BITS-1:0] fill_word = use_gen ? pat_word : word_reg;
  wire fill_vld = use_gen ? (run && rise) : word_vld_reg;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [LSC_WORD_BITS-1:0] fifo_out;
  logic ld_reg;
  lsc_fifo #(.WIDTH(LSC_WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst_b(RST_B),
    .in_valid(fill_vld),
    .in_ready(fifo_in_ready),
    .in_data(fill_word),
    .out_valid(fifo_out_valid),
    .out_ready(ld_reg),
    .out_data(fifo_out),
    .flush(!run)
  );

  // lane shifter: 6 bits per lane per word, optional dc balance by inversion
  logic [LSC_WORD_BITS-1:0] sh_reg;
  logic [2:0] slot_reg;
  logic busy_reg;
  logic [LSC_LANES-1:0] lane_reg;
  logic sclk_reg;
  logic [7:0] disp_reg [LSC_LANES];
  wire last = (slot_reg == LSC_SLOT_LAST);
  always_comb ld_reg = run && fifo_out_valid && (!busy_reg || last);
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sh_reg <= '0;
      slot_reg <= '0;
      busy_reg <= 1'b0;
      lane_reg <= '0;
      sclk_reg <= 1'b0;
      for (int l = 0; l < LSC_LANES; l++) disp_reg[l] <= '0;
    end else if (!run) begin
      busy_reg <= 1'b0;
      slot_reg <= '0;
      lane_reg <= '0; // see R17
      sclk_reg <= dsk ? ~sclk_reg : 1'b0; // see R1
    end else begin
      if (ld_reg) begin
        sh_reg <= fifo_out;
        busy_reg <= 1'b1;
        slot_reg <= '0;
      end else if (busy_reg) begin
        slot_reg <= last ? 3'h0 : slot_reg + 3'h1;
        busy_reg <= !last;
      end
      sclk_reg <= busy_reg && (slot_reg < 3'h3);
      for (int l = 0; l < LSC_LANES; l++) begin
        if (busy_reg) begin
          if (bal_en && disp_reg[l][7] && slot_reg != 3'(LSC_DCB_FLAG_BIT))
            lane_reg[l] <= ~sh_reg[l*LSC_BITS_PER_LANE + 32'(slot_reg)]; // see R16
          else
            lane_reg[l] <= sh_reg[l*LSC_BITS_PER_LANE + 32'(slot_reg)];
          disp_reg[l] <= sh_reg[l*LSC_BITS_PER_LANE + 32'(slot_reg)] ^ (bal_en && disp_reg[l][7])
                         ? disp_reg[l] + 8'h1 : disp_reg[l] - 8'h1;
        end else begin
          lane_reg[l] <= 1'b0;
        end
      end
    end
  end

  // status outputs
  logic act_reg;
  logic dska_reg;
  logic term_reg;
  logic ovr_reg;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      act_reg <= 1'b0;
      dska_reg <= 1'b0;
      term_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else begin
      act_reg <= run;
      dska_reg <= dsk && !dsk_valid;
      term_reg <= term_lvl && pwr_n; // see R10
      if (!run) ovr_reg <= 1'b0;
      else if (fill_vld && !fifo_in_ready) ovr_reg <= 1'b1;
    end
  end
  assign SERIAL_LANE_OUT = lane_reg;
  assign SERIAL_CLOCK_OUT = sclk_reg;
  assign LANES_ACTIVE = act_reg;
  assign DESKEW_ACTIVE = dska_reg;
  assign TERMINATION_DETECTED = term_reg;
  assign FIFO_OVERRUN = ovr_reg;
endmodule : lsc_top

// file: lsc_top_bench.sv
// self-checking bench for the serializer control block
`timescale 1ns/100ps
module lsc_top_bench import lsc_pkg::*; ();
  logic CLK = 0;
  logic RST_B = 0;
  logic INPUT_CLOCK = 0;
  logic [LSC_IN_BITS-1:0] PARALLEL_DATA_IN = '0;
  logic DESKEW_REQUEST_N = 1;
  logic PATTERN_LENGTH_SELECT = 0;
  logic PATTERN_GENERATOR_ENABLE = 0;
  logic POWER_DOWN_N = 0;
  logic DC_BALANCE_ENABLE = 0;
  logic TERMINATION_SENSE = 0;
  logic [LSC_LANES-1:0] SERIAL_LANE_OUT;
  logic SERIAL_CLOCK_OUT, LANES_ACTIVE, DESKEW_ACTIVE, TERMINATION_DETECTED, FIFO_OVERRUN;
  logic [LSC_WORD_BITS-1:0] rx_word;
  logic [LSC_WORD_BITS-1:0] pat_exp = '0;
  logic [LSC_IN_BITS-1:0] f, r;
  logic found, hi, pfound;
  int n_fail = 0;
  int n_compared = 0;
  int seed = 42697;
  always #2 CLK = ~CLK;
  lsc_top #(.DESKEW_CYC(8), .LOCK_CYC(4), .FIFO_DEPTH(LSC_FIFO_DEPTH)) DUT (.CLK, .RST_B,
    .INPUT_CLOCK, .PARALLEL_DATA_IN, .DESKEW_REQUEST_N, .PATTERN_LENGTH_SELECT,
    .PATTERN_GENERATOR_ENABLE, .POWER_DOWN_N, .PLL_RANGE_SELECT(1'b1),
    .FACTORY_STRAP_1(1'b0), .FACTORY_STRAP_2(1'b0),
    .DC_BALANCE_ENABLE, .TERMINATION_SENSE, .SERIAL_LANE_OUT, .SERIAL_CLOCK_OUT,
    .LANES_ACTIVE, .DESKEW_ACTIVE, .TERMINATION_DETECTED, .FIFO_OVERRUN);
  lsc_rx_model u_rx (.clk(CLK), .rst_b(RST_B), .lanes(SERIAL_LANE_OUT), .rx_word);
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk
  // first generator word after enable, from the seed and the chosen polynomial
  function automatic logic [LSC_WORD_BITS-1:0] exp_prbs(input logic len23);
    logic [22:0] st;
    logic b;
    logic [LSC_WORD_BITS-1:0] w;
    st = LSC_PRBS_SEED;
    w = '0;
    for (int i = 0; i < LSC_WORD_BITS; i++) begin
      b = len23 ? (st[LSC_PRBS23_TAP_A] ^ st[LSC_PRBS23_TAP_B])
                : (st[LSC_PRBS15_TAP_A] ^ st[LSC_PRBS15_TAP_B]);
      st = {st[21:0], b};
      w[i] = b;
    end
    return w;
  endfunction : exp_prbs
  // one input clock period, falling half then rising half
  task automatic send(input logic [LSC_IN_BITS-1:0] fa, ri);
    PARALLEL_DATA_IN = fa;
    INPUT_CLOCK = 0;
    repeat (20) @(negedge CLK);
    PARALLEL_DATA_IN = ri;
    INPUT_CLOCK = 1;
    found = 0;
    pfound = 0;
    repeat (20) begin
      @(negedge CLK);
      if (rx_word === {fa, ri}) found = 1;
      if (rx_word === pat_exp) pfound = 1;
      hi = hi | (|SERIAL_LANE_OUT);
    end
  endtask : send
  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (8) @(negedge CLK);
    RST_B = 1;
    repeat (2) send(0, 0);
    chk(LANES_ACTIVE === 1'b0, "run in power-down");
    POWER_DOWN_N = 1;
    send(0, 0);
    chk(LANES_ACTIVE === 1'b0, "run before lock");
    repeat (6) send(0, 0);
    chk(LANES_ACTIVE === 1'b1, "no run");
    DESKEW_REQUEST_N = 0;
    send(24'h5a5a5a, 24'ha5a5a5);
    chk(DESKEW_ACTIVE === 1'b1 && LANES_ACTIVE === 1'b0, "no deskew");
    chk(found === 1'b0, "data in deskew");
    repeat (9) send(24'h5a5a5a, 24'ha5a5a5);
    chk(DESKEW_ACTIVE === 1'b0, "deskew stuck");
    DESKEW_REQUEST_N = 1;
    repeat (6) send(0, 0);
    for (int i = 0; i < 6; i++) begin
      f = (i == 0) ? 24'hffffff : 24'($random(seed));
      r = (i == 0) ? 24'h000001 : 24'($random(seed));
      send(f, r);
      chk(found === 1'b1, "word lost");
    end
    for (int s = 0; s < 2; s++) begin
      PATTERN_LENGTH_SELECT = s[0];
      PATTERN_GENERATOR_ENABLE = 1;
      pat_exp = exp_prbs(s[0]);
      hi = 0;
      send(0, 0);
      chk(hi === 1'b1, "no pattern");
      chk(pfound === 1'b1, "wrong pattern");
      send(24'h123456, 24'h654321);
      chk(found === 1'b0, "data not replaced");
      PATTERN_GENERATOR_ENABLE = 0;
      send(0, 0);
      hi = 0;
      send(0, 0);
      chk(hi === 1'b0, "generator still on");
    end
    DC_BALANCE_ENABLE = 1;
    hi = 0;
    repeat (4) send(0, 0);
    chk(hi === 1'b1, "no balance inversion");
    DC_BALANCE_ENABLE = 0;
    TERMINATION_SENSE = 1;
    send(0, 0);
    chk(TERMINATION_DETECTED === 1'b1, "no termination");
    POWER_DOWN_N = 0;
    send(0, 0);
    chk(TERMINATION_DETECTED === 1'b0 && LANES_ACTIVE === 1'b0, "not down");
    POWER_DOWN_N = 1;
    send(0, 0);
    chk(LANES_ACTIVE === 1'b0, "run before relock");
    repeat (6) send(0, 0);
    chk(LANES_ACTIVE === 1'b1 && FIFO_OVERRUN === 1'b0, "no relock");
    DESKEW_REQUEST_N = 0;
    repeat (10) send(0, 0);
    chk(DESKEW_ACTIVE === 1'b0 && LANES_ACTIVE === 1'b0, "second deskew");
    DESKEW_REQUEST_N = 1;
    TERMINATION_SENSE = 0;
    send(0, 0);
    chk(LANES_ACTIVE === 1'b1 && TERMINATION_DETECTED === 1'b0, "no run after deskew");
    give_verdict();
  end
endmodule : lsc_top_bench
